// *** shared/brs_defines.svh ***
// constants for the buck reference sequencer
//
// Functional notes
// (RQ1) select codes map to seven preset targets
// (RQ2) all-ones select picks external-divider mode
// (RQ3) divider mode regulates from divider feedback input
// (RQ4) soft-start on leaving power-down or enable
// (RQ5) preset mode slews reference 1.5 V/ms
// (RQ6) divider mode ramp has fixed duration
// (RQ7) over-current: high side off, low on
// (RQ8) hold output low 1 ms, then soft-start
// (RQ9) repeated over-current repeats hiccup indefinitely
// (RQ10) no switching until lockout released
// (RQ11) lockout while running stops switching
// (RQ12) enable low shuts converter down
// (RQ13) enable high runs after soft-start
// (RQ14) over-temperature turns converter output off
// (RQ15) over-temperature clear restarts with soft-start
// (RQ16) select change slews glitch-free to new level
// (RQ17) board never swaps preset and divider live
// (RQ18) divider-mode ramp lasts about 1.2 ms
// (RQ19) control runs from 4 MHz switching clock; logic runs on aclk, switch_tick every 12 cycles (about 4.17 MHz)
// (RQ20) any shutdown resets reference to zero
`ifndef BRS_DEFINES_SVH
`define BRS_DEFINES_SVH

`define BRS_CLK_FREQ_KHZ   50000
`define BRS_SW_FREQ_KHZ    4000
`define BRS_SW_DIV_CYCLES  (`BRS_CLK_FREQ_KHZ / `BRS_SW_FREQ_KHZ)
`define BRS_CLK_MHZ        (`BRS_CLK_FREQ_KHZ / 1000)

// preset slew: 3 mV every 2 us gives 1.5 V/ms
`define BRS_RAMP_STEP_MV   12'h003
`define BRS_RAMP_STEP_US   2
`define BRS_RAMP_STEP_CYC  (`BRS_RAMP_STEP_US * `BRS_CLK_MHZ)
// divider mode: progress in us, 1200 us total
`define BRS_EXT_RAMP_US    1200
`define BRS_EXT_STEP_CYC   (`BRS_CLK_MHZ)
`define BRS_EXT_REF_MV     12'h25b
`define BRS_OC_HOLD_US     1000

// preset targets in mV
`define BRS_MV_CODE0       12'hce4
`define BRS_MV_CODE1       12'h9c4
`define BRS_MV_CODE2       12'h708
`define BRS_MV_CODE3       12'h5dc
`define BRS_MV_CODE4       12'h4e2
`define BRS_MV_CODE5       12'h4b0
`define BRS_MV_CODE6       12'h320
`define BRS_CODE_EXT       3'h7

// register word indices, byte address over four
`define BRS_REG_CONTROL    6'h00
`define BRS_REG_STATUS     6'h01
`define BRS_REG_LEVEL      6'h02
`define BRS_CONTROL_RESET  1'h1
`define BRS_RESP_OKAY      2'h0
`define BRS_RESP_SLVERR    2'h2

// control, status and level field positions
`define BRS_CTRL_ENABLE    0
`define BRS_CTRL_CLEAR     1
`define BRS_ST_STATE       0
`define BRS_ST_SW_EN       2
`define BRS_ST_EXT         3
`define BRS_ST_HS          4
`define BRS_ST_LS          5
`define BRS_ST_SS          6
`define BRS_ST_HICCUP      8
`define BRS_LV_REF         0
`define BRS_LV_TARGET      16

`endif

// *** shared/brs_pkg.sv ***
// types for the buck reference sequencer
package brs_pkg;

    typedef enum logic [1:0] {
        BRS_OFF,
        BRS_HOLD,
        BRS_RAMP,
        BRS_RUN
    } brs_state_e;

    typedef struct packed {
        brs_state_e  state;
        logic        ext_mode;
        logic [11:0] ref_mv;
        logic [11:0] target_mv;
        logic [7:0]  step_cnt;
        logic [10:0] progress;
        logic [15:0] hold_cnt;
        logic [3:0]  sw_cnt;
        logic        sw_tick;
        logic        hs_on;
        logic        ls_on;
        logic        sw_en;
        logic        ss_active;
        logic [7:0]  hiccups;
        logic        sw_enable_bit;
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [5:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } brs_regs_s;

endpackage

// *** core/brs_sequencer.sv ***
// reference ramp, hiccup and start-up gating with an AXI4-Lite slave
`timescale 1ns/100ps
`include "brs_defines.svh"

module brs_sequencer
    import brs_pkg::*;
#(
    parameter int OC_HOLD_CYCLES = `BRS_OC_HOLD_US * `BRS_CLK_MHZ
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // board pins and analog indications
    input  wire logic        level_select_bit0,
    input  wire logic        level_select_bit1,
    input  wire logic        level_select_bit2,
    input  wire logic        enable,
    input  wire logic        input_undervoltage_lockout,
    input  wire logic        over_temperature,
    input  wire logic        over_current,
    // power stage and reference
    output logic             high_side_on,
    output logic             low_side_on,
    output logic             switching_enable,
    output logic             switch_tick,
    output logic             use_divider_feedback,
    output logic             soft_start_active,
    output logic [11:0]      reference_mv,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    brs_regs_s r;
    brs_regs_s next_r;

    logic [2:0]  preset_level_code;
    logic [11:0] code_mv;
    logic        run_ok;
    logic        ramp_up;
    logic        ramp_down;
    logic [11:0] ext_ref_mv;
    logic [31:0] rd_status;
    logic [31:0] rd_level;
    logic [31:0] rd_word;
    logic        rd_err;

    assign preset_level_code = {level_select_bit2, level_select_bit1,
                                level_select_bit0};

    // (RQ1) preset code decode
    always_comb begin
        case (preset_level_code)
            3'h0:    code_mv = `BRS_MV_CODE0;
            3'h1:    code_mv = `BRS_MV_CODE1;
            3'h2:    code_mv = `BRS_MV_CODE2;
            3'h3:    code_mv = `BRS_MV_CODE3;
            3'h4:    code_mv = `BRS_MV_CODE4;
            3'h5:    code_mv = `BRS_MV_CODE5;
            3'h6:    code_mv = `BRS_MV_CODE6;
            default: code_mv = 12'h000;
        endcase
    end

    // (RQ10) (RQ12) (RQ14) start conditions
    assign run_ok = enable && r.sw_enable_bit &&
                    !input_undervoltage_lockout && !over_temperature;

    // (RQ5) step only while a whole step still fits
    // differences, not sums, so no carry can wrap
    assign ramp_up   = (r.ref_mv < r.target_mv) &&
                       (r.target_mv - r.ref_mv >= `BRS_RAMP_STEP_MV);
    assign ramp_down = (r.ref_mv > r.target_mv) &&
                       (r.ref_mv - r.target_mv >= `BRS_RAMP_STEP_MV);

    // (RQ6) divider ramp: half a mV per us of progress
    assign ext_ref_mv = {2'h0, r.progress[10:1]};

    // read word assembly
    always_comb begin
        rd_status = 32'h0000_0000;
        rd_status[`BRS_ST_STATE +: 2]   = r.state;
        rd_status[`BRS_ST_SW_EN]        = r.sw_en;
        rd_status[`BRS_ST_EXT]          = r.ext_mode;
        rd_status[`BRS_ST_HS]           = r.hs_on;
        rd_status[`BRS_ST_LS]           = r.ls_on;
        rd_status[`BRS_ST_SS]           = r.ss_active;
        rd_status[`BRS_ST_HICCUP +: 8]  = r.hiccups;
        rd_level = 32'h0000_0000;
        rd_level[`BRS_LV_REF +: 12]     = r.ref_mv;
        rd_level[`BRS_LV_TARGET +: 12]  = r.target_mv;
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        case (s_axi_araddr[7:2])
            `BRS_REG_CONTROL: rd_word = {31'h0, r.sw_enable_bit};
            `BRS_REG_STATUS:  rd_word = rd_status;
            `BRS_REG_LEVEL:   rd_word = rd_level;
            default: begin
                rd_word = 32'h0000_0000;
                rd_err  = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.sw_tick = 1'b0;

        // (RQ19) switching-rate enable
        if (r.sw_cnt == 4'(`BRS_SW_DIV_CYCLES - 1)) begin
            next_r.sw_cnt  = 4'h0;
            next_r.sw_tick = 1'b1;
        end else begin
            next_r.sw_cnt = r.sw_cnt + 4'h1;
        end

        // (RQ16) preset target follows pins live
        if (!r.ext_mode) begin
            next_r.target_mv = code_mv;
        end

        case (r.state)
            BRS_OFF: begin
                next_r.hs_on     = 1'b0;
                next_r.ls_on     = 1'b0;
                next_r.sw_en     = 1'b0;
                next_r.ss_active = 1'b0;
                next_r.ref_mv    = 12'h000;
                // (RQ4) (RQ13) (RQ15) leave power-down by ramp
                if (run_ok) begin
                    // (RQ2) all-ones picks divider mode
                    next_r.ext_mode  = (preset_level_code == `BRS_CODE_EXT);
                    next_r.target_mv = code_mv;
                    next_r.step_cnt  = 8'h00;
                    next_r.progress  = 11'h000;
                    next_r.ss_active = 1'b1;
                    next_r.sw_en     = 1'b1;
                    next_r.hs_on     = 1'b1;
                    next_r.state     = BRS_RAMP;
                end
            end
            BRS_HOLD: begin
                // (RQ8) output held low for the hold-off
                if (r.hold_cnt == 16'(OC_HOLD_CYCLES - 1)) begin
                    next_r.hold_cnt = 16'h0000;
                    next_r.ls_on    = 1'b0;
                    next_r.sw_en    = 1'b0;
                    next_r.state    = BRS_OFF;
                end else begin
                    next_r.hold_cnt = r.hold_cnt + 16'h0001;
                end
                // (RQ11) (RQ12) (RQ14) shutdown cuts the hold short
                if (!run_ok) begin
                    next_r.hold_cnt = 16'h0000;
                    next_r.ls_on    = 1'b0;
                    next_r.sw_en    = 1'b0;
                    next_r.state    = BRS_OFF;
                end
            end
            BRS_RAMP, BRS_RUN: begin
                next_r.step_cnt = r.step_cnt + 8'h01;
                if (r.ext_mode) begin
                    // (RQ6) (RQ18) fixed-time ramp in divider mode
                    if (r.step_cnt == 8'(`BRS_EXT_STEP_CYC - 1)) begin
                        next_r.step_cnt = 8'h00;
                        if (r.progress != 11'(`BRS_EXT_RAMP_US)) begin
                            next_r.progress = r.progress + 11'h001;
                        end
                    end
                    if (r.progress == 11'(`BRS_EXT_RAMP_US)) begin
                        next_r.ref_mv = `BRS_EXT_REF_MV;
                        next_r.state  = BRS_RUN;
                    end else begin
                        next_r.ref_mv = ext_ref_mv;
                    end
                end else if (r.step_cnt == 8'(`BRS_RAMP_STEP_CYC - 1)) begin
                    // (RQ5) (RQ16) fixed step toward target, clamped
                    next_r.step_cnt = 8'h00;
                    if (ramp_up) begin
                        next_r.ref_mv = r.ref_mv + `BRS_RAMP_STEP_MV;
                    end else if (ramp_down) begin
                        next_r.ref_mv = r.ref_mv - `BRS_RAMP_STEP_MV;
                    end else begin
                        next_r.ref_mv = r.target_mv;
                        next_r.state  = BRS_RUN;
                    end
                end
                // soft-start ends once the first target is reached
                if (next_r.state == BRS_RUN) begin
                    next_r.ss_active = 1'b0;
                end
                next_r.hs_on = 1'b1;
                // (RQ11) (RQ12) (RQ14) (RQ20) any cause drops to zero
                if (!run_ok) begin
                    next_r.state     = BRS_OFF;
                    next_r.hs_on     = 1'b0;
                    next_r.sw_en     = 1'b0;
                    next_r.ss_active = 1'b0;
                    next_r.ref_mv    = 12'h000;
                end else if (over_current) begin
                    // (RQ7) (RQ9) trip: pull output low, retry later
                    next_r.state     = BRS_HOLD;
                    next_r.hs_on     = 1'b0;
                    next_r.ls_on     = 1'b1;
                    next_r.ss_active = 1'b0;
                    next_r.ref_mv    = 12'h000;
                    next_r.hold_cnt  = 16'h0000;
                    next_r.hiccups   = r.hiccups + 8'h01;
                end
            end
            default: begin
                next_r.state = BRS_OFF;
            end
        endcase

        // write channel: address and data taken in either order
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_got  = 1'b1;
            next_r.awready = 1'b0;
            next_r.waddr   = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_got  = 1'b1;
            next_r.wready = 1'b0;
            next_r.wdata  = s_axi_wdata;
            next_r.wstrb  = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            if (r.waddr == `BRS_REG_CONTROL) begin
                next_r.bresp = `BRS_RESP_OKAY;
                if (r.wstrb[0]) begin
                    next_r.sw_enable_bit = r.wdata[`BRS_CTRL_ENABLE];
                end
                // write-one clears the retry counter
                if (r.wstrb[0] && r.wdata[`BRS_CTRL_CLEAR]) begin
                    next_r.hiccups = 8'h00;
                end
            end else if (r.waddr == `BRS_REG_STATUS ||
                         r.waddr == `BRS_REG_LEVEL) begin
                next_r.bresp = `BRS_RESP_OKAY;
            end else begin
                next_r.bresp = `BRS_RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid  = 1'b0;
            next_r.awready = 1'b1;
            next_r.wready  = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && r.arready) begin
            next_r.arready = 1'b0;
            next_r.rvalid  = 1'b1;
            next_r.rdata   = rd_word;
            next_r.rresp   = rd_err ? `BRS_RESP_SLVERR : `BRS_RESP_OKAY;
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid  = 1'b0;
            next_r.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r               <= '0;
            r.state         <= BRS_OFF;
            r.sw_enable_bit <= `BRS_CONTROL_RESET;
            r.awready       <= 1'b1;
            r.wready        <= 1'b1;
            r.arready       <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign high_side_on         = r.hs_on;
    assign low_side_on          = r.ls_on;
    assign switching_enable     = r.sw_en;
    // free-running rate pulse; the power stage gates its own edges
    assign switch_tick          = r.sw_tick;
    // (RQ3) divider feedback path in divider mode
    assign use_divider_feedback = r.ext_mode;
    assign soft_start_active    = r.ss_active;
    assign reference_mv         = r.ref_mv;
    assign s_axi_awready        = r.awready;
    assign s_axi_wready         = r.wready;
    assign s_axi_bvalid         = r.bvalid;
    assign s_axi_bresp          = r.bresp;
    assign s_axi_arready        = r.arready;
    assign s_axi_rvalid         = r.rvalid;
    assign s_axi_rdata          = r.rdata;
    assign s_axi_rresp          = r.rresp;

endmodule

// *** verification/brs_board_model.sv ***
// board logic driving the level-select and enable pins
`timescale 1ns/100ps
module brs_board_model (
    // clock and requests
    input  wire logic       aclk,
    input  wire logic [2:0] code_req,
    input  wire logic       en_req,
    // pins
    output logic            level_select_bit0,
    output logic            level_select_bit1,
    output logic            level_select_bit2,
    output logic            enable
);
    logic [2:0] code = 3'h6;
    assign {level_select_bit2, level_select_bit1, level_select_bit0} = code;
    always @(posedge aclk) begin
        enable <= en_req;
        if (!enable || ((code_req == 3'h7) == (code == 3'h7))) begin
            code <= code_req;
        end
    end
endmodule

// *** verification/brs_sequencer_asserts.sv ***
// pin-level properties of the reference sequencer
`timescale 1ns/100ps
module brs_sequencer_asserts #(
    parameter int OC_HOLD_CYCLES = 50000
) (
    // clock and inputs
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        level_select_bit0,
    input wire logic        level_select_bit1,
    input wire logic        level_select_bit2,
    input wire logic        enable,
    input wire logic        input_undervoltage_lockout,
    input wire logic        over_temperature,
    input wire logic        over_current,
    // outputs
    input wire logic        high_side_on,
    input wire logic        low_side_on,
    input wire logic        switching_enable,
    input wire logic        switch_tick,
    input wire logic        use_divider_feedback,
    input wire logic        soft_start_active,
    input wire logic [11:0] reference_mv
);
    logic [15:0] low_cnt;
    wire logic   run_pins = enable && !input_undervoltage_lockout
                            && !over_temperature;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        low_cnt <= (!aresetn || !low_side_on) ? 16'h0 : low_cnt + 16'h1;
    end
    AST_LOCKOUT_STOP: assert property (input_undervoltage_lockout
        |=> !switching_enable && reference_mv == 12'h0) else $error("input_undervoltage_lockout");
    AST_ENABLE_LOW: assert property (!enable
        |=> !switching_enable && !high_side_on) else $error("enable low");
    AST_HOT_STOP: assert property (over_temperature
        |=> !switching_enable && !high_side_on) else $error("hot");
    AST_OC_TRIP: assert property (over_current && high_side_on
        && run_pins
        |=> low_side_on && !high_side_on && reference_mv == 12'h0)
        else $error("trip");
    AST_HOLD_LEN: assert property (low_side_on
        |-> low_cnt < OC_HOLD_CYCLES) else $error("hold too long");
    AST_RESTART: assert property ($fell(low_side_on) && run_pins
        |-> ##[0:2] high_side_on && soft_start_active) else $error("retry");
    AST_START_ZERO: assert property ($rose(switching_enable)
        |-> soft_start_active && reference_mv <= 12'h3) else $error("start");
    AST_SLEW: assert property (!use_divider_feedback && high_side_on
        && $past(high_side_on)
        |-> reference_mv <= $past(reference_mv) + 12'h3
        && $past(reference_mv) <= reference_mv + 12'h3) else $error("slew");
    AST_MODE: assert property ($rose(switching_enable)
        |-> use_divider_feedback == $past(level_select_bit0
        && level_select_bit1 && level_select_bit2)) else $error("mode");
    AST_TICK: assert property (switch_tick
        |=> (!switch_tick) [*8] ##1 (!switch_tick) [*3] ##1 switch_tick)
        else $error("tick");
    C_START: cover property ($rose(switching_enable));
    C_TRIP: cover property ($rose(low_side_on));
    C_DIV: cover property ($fell(soft_start_active) && use_divider_feedback);
endmodule
bind brs_sequencer brs_sequencer_asserts #(
    .OC_HOLD_CYCLES(OC_HOLD_CYCLES)
) u_asserts (.*);

// *** verification/test_buck_reference_sequencer.sv ***
// self-checking bench for the reference sequencer
`timescale 1ns/100ps
module test_buck_reference_sequencer;
    localparam int HOLD = 200;
    logic aclk = 1'b0, aresetn = 1'b0, en_req = 1'b1, lockout = 1'b1;
    logic ot = 1'b0, oc = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] code_req = 3'h6;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic level_select_bit0, level_select_bit1, level_select_bit2, enable;
    logic high_side_on, low_side_on, switching_enable, switch_tick;
    logic use_divider_feedback, soft_start_active, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [11:0] reference_mv;
    logic [11:0] tbl [7] = '{12'hce4, 12'h9c4, 12'h708, 12'h5dc, 12'h4e2,
                             12'h4b0, 12'h320};
    int bad_count = 0, tests_run = 0, n;
    brs_board_model board (.*);
    brs_sequencer #(.OC_HOLD_CYCLES(HOLD)) dut (.*,
        .input_undervoltage_lockout(lockout), .over_temperature(ot),
        .over_current(oc));
    initial begin
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_reset();
        repeat (5) @(posedge aclk);
        chk(32'(switching_enable), 32'h0); // held off in lockout
        axi_rd(8'h00);
        chk(rd, 32'h1); // control enable after reset
        axi_rd(8'h3c);
        chk({rd[29:0], resp}, 32'h2); // unmapped read refused
        axi_wr(8'h3c, 32'h0);
        chk(32'(resp), 32'h2); // unmapped write refused
    endtask
    task automatic t_preset();
        lockout <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(32'({switching_enable, soft_start_active}), 32'h3);
        while (reference_mv < 12'h3) @(posedge aclk);
        n = 0;
        while (reference_mv < 12'h6) begin
            @(posedge aclk);
            n++;
        end
        chk(32'(n), 32'd100); // cycles per 3 mV step
        for (int c = 0; c < 7; c++) begin
            code_req <= 3'(c);
            repeat (4) @(posedge aclk);
            axi_rd(8'h08);
            chk(32'(rd[27:16]), 32'(tbl[c])); // target per code
        end
    endtask
    task automatic t_hiccup();
        for (int k = 0; k < 2; k++) begin
            oc <= 1'b1;
            @(posedge aclk);
            oc <= 1'b0;
            while (low_side_on !== 1'b1) @(posedge aclk);
            chk(32'({high_side_on, reference_mv}), 32'h0);
            n = 0;
            while (low_side_on === 1'b1) begin
                @(posedge aclk);
                n++;
            end
            chk(32'(n), 32'(HOLD)); // hold length
            repeat (3) @(posedge aclk);
            chk(32'({high_side_on, soft_start_active}), 32'h3);
        end
        oc <= 1'b1;
        @(posedge aclk);
        oc <= 1'b0;
        lockout <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'({low_side_on, switching_enable}), 32'h0); // hold cut
        lockout <= 1'b0;
        axi_rd(8'h04);
        chk(32'(rd[15:8]), 32'h3); // three trips counted
        axi_wr(8'h00, 32'h3);
        chk(32'(resp), 32'h0); // control write accepted
        axi_rd(8'h04);
        chk(32'(rd[15:8]), 32'h0); // count cleared by software
    endtask
    task automatic t_shutdown();
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: en_req <= 1'b0;
                1: lockout <= 1'b1;
                2: ot <= 1'b1;
                default: axi_wr(8'h00, 32'h0);
            endcase
            repeat (3) @(posedge aclk);
            chk(32'({switching_enable, reference_mv}), 32'h0);
            {en_req, lockout, ot} <= 3'h4;
            if (i == 3) axi_wr(8'h00, 32'h1);
            repeat (3) @(posedge aclk);
            chk(32'(soft_start_active), 32'h1); // fresh ramp
        end
    endtask
    task automatic t_divider();
        en_req <= 1'b0;
        code_req <= 3'h7;
        repeat (4) @(posedge aclk);
        en_req <= 1'b1;
        while (switching_enable !== 1'b1) @(posedge aclk);
        chk(32'(use_divider_feedback), 32'h1); // divider mode
        n = 0;
        while (soft_start_active === 1'b1) begin
            @(posedge aclk);
            n++;
        end
        chk(32'(n > 59900 && n < 60100), 32'h1); // ramp time
        code_req <= 3'h6;
        repeat (3) @(posedge aclk);
        chk(32'(reference_mv), 32'h25b); // divider reference
        chk(32'(level_select_bit0), 32'h1); // select held by board
    endtask
    task automatic print_verdict();
        $display("TB: bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_preset();
        t_hiccup();
        t_shutdown();
        t_divider();
        print_verdict();
    end
    // about 62k cycles expected; cut off well past that
    initial begin
        #2_000_000;
        bad_count++;
        print_verdict();
    end
endmodule
